/* logic/bdi_top.sv */
// Memory and I/O decode, peripheral registers, timer and interrupt routing
`timescale 1ns/100ps
`include "bdi_map.svh"
module bdi_top
	import bdi_pkg::*;
#(
	parameter int ROM_BYTES = `BDI_ROM_BYTES,
	parameter int RAM_BYTES = `BDI_RAM_BYTES
) (
	// Clock, reset, enable
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	// CPU bus
	input  wire bdi_req_s    req,
	output logic [7:0]       rdata,
	output logic             rvalid,
	output logic             rom_sel,
	output logic             ram_sel,
	// Parallel ports
	input  wire logic [7:0]  port1_in,
	output logic [7:0]       port1_out,
	output logic             port1_oe,
	input  wire logic [7:0]  port2_in,
	output logic [7:0]       port2_out,
	output logic             port2_oe,
	input  wire logic [5:0]  port34_in,
	output logic [5:0]       port34_out,
	// Strobes from the control lines
	input  wire logic        port1_stb_n,
	input  wire logic        port2_stb_n,
	// Interrupts
	input  wire logic        user_irq_n,
	output bdi_irq_s         irq,
	output logic [7:0]       irq_vector,
	output logic             irq_any,
	// Timing marks
	output logic             timer_tc,
	output logic             instr_tick
);
	// ---------------------------------------------
	// Decode
	// ---------------------------------------------
	localparam int RAM_AW = $clog2(RAM_BYTES);
	logic        hit_rom;
	logic        hit_ram;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_a;
	assign hit_rom = !req.io && (req.addr < 16'(ROM_BYTES));
	assign hit_ram = !req.io && (req.addr >= `BDI_RAM_BASE)
		&& (req.addr < (`BDI_RAM_BASE + 16'(RAM_BYTES)));
	assign io_a    = req.addr[7:0];
	assign io_wr   = req.io && req.wr;
	assign io_rd   = req.io && req.rd;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rom_sel <= 1'b0;
			ram_sel <= 1'b0;
		end else if (ce) begin
			rom_sel <= hit_rom && (req.rd || req.wr);
			ram_sel <= hit_ram && (req.rd || req.wr);
		end
	end

	// ---------------------------------------------
	// Read/write memory
	// ---------------------------------------------
	logic [7:0] ram [RAM_BYTES];
	logic [7:0] ram_q;
	always_ff @(posedge clock) begin
		if (ce && hit_ram && req.wr) begin
			ram[req.addr[RAM_AW-1:0]] <= req.wdata;
		end
		if (ce)
			ram_q <= ram[req.addr[RAM_AW-1:0]];
	end

	// ---------------------------------------------
	// Command and port registers
	// ---------------------------------------------
	logic [7:0] cmd;
	logic [7:0] p1_latch;
	logic [7:0] p2_latch;
	logic       p1_intr;
	logic       p2_intr;
	logic       p1_stb_d;
	logic       p2_stb_d;
	logic       p1_rise;
	logic       p2_rise;
	logic       p1_strobed;
	logic       p2_strobed;
	assign p1_strobed = cmd[`BDI_CMD_P1_STB];
	assign p2_strobed = cmd[`BDI_CMD_P2_STB];
	assign p1_rise    = port1_stb_n && !p1_stb_d;
	assign p2_rise    = port2_stb_n && !p2_stb_d;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cmd        <= 8'h00;
			port1_out  <= 8'h00;
			port2_out  <= 8'h00;
			port34_out <= 6'h00;
		end else if (ce && io_wr) begin
			case (io_a)
				`BDI_IO_CMD:    cmd        <= req.wdata;
				`BDI_IO_PORT1:  port1_out  <= req.wdata;
				`BDI_IO_PORT2:  port2_out  <= req.wdata;
				`BDI_IO_PORT34: port34_out <= req.wdata[5:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			port1_oe <= 1'b0;
			port2_oe <= 1'b0;
		end else if (ce) begin
			port1_oe <= cmd[0];
			port2_oe <= cmd[1];
		end
	end

	// Strobe lines are plain inputs; edge found against last sample
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			p1_stb_d <= 1'b1;
			p2_stb_d <= 1'b1;
		end else if (ce) begin
			p1_stb_d <= port1_stb_n;
			p2_stb_d <= port2_stb_n;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			p1_latch <= 8'h00;
			p2_latch <= 8'h00;
		end else if (ce) begin
			if (p1_rise && p1_strobed && !cmd[0])
				p1_latch <= port1_in;
			if (p2_rise && p2_strobed && !cmd[1])
				p2_latch <= port2_in;
		end
	end

	// Set wins over the clear made by the port access
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			p1_intr <= 1'b0;
			p2_intr <= 1'b0;
		end else if (ce) begin
			if (p1_rise && p1_strobed)
				p1_intr <= 1'b1;
			else if (!p1_strobed || (req.io && (req.rd || req.wr) && io_a == `BDI_IO_PORT1))
				p1_intr <= 1'b0;
			if (p2_rise && p2_strobed)
				p2_intr <= 1'b1;
			else if (!p2_strobed || (req.io && (req.rd || req.wr) && io_a == `BDI_IO_PORT2))
				p2_intr <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Timer
	// ---------------------------------------------
	localparam int TREF_CYC = `BDI_TREF_CYC;
	logic [8:0]  ref_div;
	logic        ref_tick;
	logic [13:0] t_len;
	logic [1:0]  t_mode;
	logic [13:0] t_cnt;
	logic        t_flag;
	logic        stop_tc;
	bdi_tstate_e t_state;
	bdi_tstate_e next_t_state;
	logic        tc_now;
	logic        t_start;
	logic        stat_rd;

	// Reference tick derived here; the part sees no second clock
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ref_div  <= 9'h000;
			ref_tick <= 1'b0;
		end else if (ce) begin
			ref_tick <= (ref_div == 9'(TREF_CYC - 1));
			ref_div  <= (ref_div == 9'(TREF_CYC - 1)) ? 9'h000 : ref_div + 9'h001;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			t_len  <= 14'h0000;
			t_mode <= 2'h0;
		end else if (ce && io_wr) begin
			if (io_a == `BDI_IO_TLOW)
				t_len[7:0] <= req.wdata;
			if (io_a == `BDI_IO_THIGH) begin
				t_len[13:8] <= req.wdata[5:0];
				t_mode      <= req.wdata[7:6];
			end
		end
	end

	assign t_start = io_wr && io_a == `BDI_IO_CMD && req.wdata[7:6] == `BDI_TCMD_START;
	assign tc_now  = ref_tick && t_state != BDI_T_IDLE && t_cnt <= 14'h0001;

	always_comb begin
		next_t_state = t_state;
		case (t_state)
			BDI_T_IDLE: if (t_start) next_t_state = BDI_T_RUN;
			BDI_T_RUN, BDI_T_LAST: begin
				if (io_wr && io_a == `BDI_IO_CMD && req.wdata[7:6] == `BDI_TCMD_STOP)
					next_t_state = BDI_T_IDLE;
				else if (tc_now && (!t_mode[0] || stop_tc))
					next_t_state = BDI_T_IDLE;
			end
			default: next_t_state = BDI_T_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			t_state <= BDI_T_IDLE;
			t_cnt   <= 14'h0000;
			stop_tc <= 1'b0;
		end else if (ce) begin
			t_state <= next_t_state;
			if (t_start) begin
				t_cnt   <= t_len;
				stop_tc <= 1'b0;
			end else if (tc_now) begin
				t_cnt <= t_len;
			end else if (ref_tick && t_state != BDI_T_IDLE) begin
				t_cnt <= t_cnt - 14'h0001;
			end
			if (io_wr && io_a == `BDI_IO_CMD && req.wdata[7:6] == `BDI_TCMD_STOPTC)
				stop_tc <= 1'b1;
		end
	end

	// Completion flag; a status read clears it unless completion lands now
	assign stat_rd = io_rd && io_a == `BDI_IO_CMD;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			t_flag   <= 1'b0;
			timer_tc <= 1'b0;
		end else if (ce) begin
			timer_tc <= tc_now;
			if (tc_now)
				t_flag <= 1'b1;
			else if (stat_rd)
				t_flag <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Instruction pace mark
	// ---------------------------------------------
	// Four CPU clocks per shortest instruction; slot count is nominal
	localparam int INSTR_CYC = `BDI_INSTR_CYC;
	logic [6:0] instr_div;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			instr_div  <= 7'h00;
			instr_tick <= 1'b0;
		end else if (ce) begin
			instr_tick <= (instr_div == 7'(INSTR_CYC - 1));
			instr_div  <= (instr_div == 7'(INSTR_CYC - 1)) ? 7'h00 : instr_div + 7'h01;
		end
	end

	// ---------------------------------------------
	// Read data
	// ---------------------------------------------
	logic       ram_rd_d;
	logic [7:0] io_q;
	always_comb begin
		io_q = 8'h00;
		case (io_a)
			`BDI_IO_CMD:    io_q = {1'b0, t_flag, cmd[`BDI_CMD_P2_IEN], 1'b0, p2_intr,
				cmd[`BDI_CMD_P1_IEN], 1'b0, p1_intr};
			`BDI_IO_PORT1:  io_q = p1_strobed ? p1_latch : (cmd[0] ? port1_out : port1_in);
			`BDI_IO_PORT2:  io_q = p2_strobed ? p2_latch : (cmd[1] ? port2_out : port2_in);
			`BDI_IO_PORT34: io_q = {2'b00, port34_in};
			`BDI_IO_TLOW:   io_q = t_cnt[7:0];
			`BDI_IO_THIGH:  io_q = {t_mode, t_cnt[13:8]};
			default:        io_q = 8'h00;
		endcase
	end

	// RAM reads answer one cycle later than I/O reads
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata    <= 8'h00;
			rvalid   <= 1'b0;
			ram_rd_d <= 1'b0;
		end else if (ce) begin
			ram_rd_d <= hit_ram && req.rd;
			if (ram_rd_d) begin
				rdata  <= ram_q;
				rvalid <= 1'b1;
			end else if (io_rd) begin
				rdata  <= (io_a <= `BDI_IO_THIGH) ? io_q : 8'h00;
				rvalid <= 1'b1;
			end else begin
				rvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------
	// Interrupt routing
	// ---------------------------------------------
	bdi_irq_s next_irq;
	always_comb begin
		next_irq.trap = !user_irq_n;
		next_irq.r75  = t_flag;
		next_irq.r65  = p2_intr && cmd[`BDI_CMD_P2_IEN] && p2_strobed;
		next_irq.r55  = p1_intr && cmd[`BDI_CMD_P1_IEN] && p1_strobed;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq        <= '0;
			irq_vector <= 8'h00;
			irq_any    <= 1'b0;
		end else if (ce) begin
			irq     <= next_irq;
			irq_any <= |next_irq;
			if (next_irq.trap)
				irq_vector <= `BDI_VEC_TRAP;
			else if (next_irq.r75)
				irq_vector <= `BDI_VEC_R75;
			else if (next_irq.r65)
				irq_vector <= `BDI_VEC_R65;
			else if (next_irq.r55)
				irq_vector <= `BDI_VEC_R55;
			else
				irq_vector <= 8'h00;
		end
	end

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_rom_access;
		ce && !req.io && req.rd && req.addr <= 16'h0fff;
	endsequence
	sequence s_tc_seen;
		ce && tc_now;
	endsequence

	AST_ROM_SEL: assert property (s_rom_access |=> rom_sel)
		else $error("ROM select missing");
	AST_RAM_RANGE: assert property (ram_sel |->
		$past(req.addr) >= 16'h3f00 && $past(req.addr) <= 16'h3fff)
		else $error("RAM select outside window");
	AST_IO_TLOW: assert property (ce && io_rd && io_a == 8'h04 && !ram_rd_d
		|=> rvalid && rdata == $past(t_cnt[7:0]))
		else $error("Timer low byte read wrong");
	AST_VEC_TRAP: assert property (irq.trap |-> irq_vector == 8'h24)
		else $error("Trap vector wrong");
	AST_VEC_R55: assert property (irq.r55 && !irq.r65 && !irq.r75 && !irq.trap
		|-> irq_vector == 8'h2c)
		else $error("Lowest vector wrong");
	AST_TRAP_ROUTE: assert property (ce && !user_irq_n |=> irq.trap)
		else $error("User request not on trap");
	AST_REF_TICK: assert property (ce && ref_tick |-> ref_div == 9'h000 ##1 !ref_tick)
		else $error("Reference divider misaligned");
	AST_INSTR_SLOT: assert property (instr_tick && ce |=> !instr_tick)
		else $error("Instruction mark too long");
	AST_TC_FLAG: assert property (s_tc_seen |=> t_flag && timer_tc ##1 irq.r75)
		else $error("Timer completion not raised");
	AST_PORT_MODE: assert property (!p1_strobed |=> !irq.r55 || $past(p1_strobed, 2))
		else $error("Port 1 request outside strobed mode");
endmodule // bdi_top

/* logic/bdi_map.svh */
// Address map, field positions and timing counts of the board decode block
`ifndef BDI_MAP_SVH
`define BDI_MAP_SVH
`define BDI_ROM_BASE    16'h0000
`define BDI_ROM_BYTES   4096
`define BDI_RAM_BASE    16'h3f00
`define BDI_RAM_BYTES   256
`define BDI_IO_CMD      8'h00
`define BDI_IO_PORT1    8'h01
`define BDI_IO_PORT2    8'h02
`define BDI_IO_PORT34   8'h03
`define BDI_IO_TLOW     8'h04
`define BDI_IO_THIGH    8'h05
`define BDI_VEC_TRAP    8'h24
`define BDI_VEC_R75     8'h3c
`define BDI_VEC_R65     8'h34
`define BDI_VEC_R55     8'h2c
`define BDI_CMD_P1_STB  2
`define BDI_CMD_P2_STB  3
`define BDI_CMD_P1_IEN  4
`define BDI_CMD_P2_IEN  5
`define BDI_TCMD_STOP   2'h1
`define BDI_TCMD_STOPTC 2'h2
`define BDI_TCMD_START  2'h3
`define BDI_CLK_MHZ     50
`define BDI_TREF_NS     8140
`define BDI_TREF_CYC    ((`BDI_TREF_NS * `BDI_CLK_MHZ) / 1000)
`define BDI_INSTR_CLKS  4
`define BDI_INSTR_NS    2030
`define BDI_INSTR_CYC   ((`BDI_INSTR_NS * `BDI_CLK_MHZ) / 1000)
`endif

/* logic/bdi_pkg.sv */
// Types shared by the board decode block
package bdi_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic        io;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} bdi_req_s;
	typedef struct packed {
		logic trap;
		logic r75;
		logic r65;
		logic r55;
	} bdi_irq_s;
	typedef enum logic [1:0] {BDI_T_IDLE, BDI_T_RUN, BDI_T_LAST} bdi_tstate_e;
endpackage

/* dv/bdi_cpu_model.sv */
// Processor bus master model facing the board decode block
`timescale 1ns/100ps
module bdi_cpu_model
	import bdi_pkg::*;
(
	// Clock
	input  wire logic       clock,
	// Bus toward the block
	output bdi_req_s        req,
	input  wire logic [7:0] rdata,
	input  wire logic       rvalid
);
	// Serial bits live in processor software only, nothing to drive here
	initial req = '0;

	// ---------------------------------------------
	// One bus cycle
	// ---------------------------------------------
	// Strobe held across the taking edge, then dropped; stale address inverted so nothing leans on it
	task automatic cycle(input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		q = 8'hxx;
		@(posedge clock);
		#1 req.addr = a;
		req.io = io;
		req.rd = !wr;
		req.wr = wr;
		req.wdata = d;
		@(posedge clock);
		#1 req.rd = 1'b0;
		req.wr = 1'b0;
		req.addr = ~a;
		req.wdata = ~d;
		for (int n = 0; n < 4 && !wr; n++) begin
			if (rvalid === 1'b1) begin
				q = rdata;
				break;
			end
			@(posedge clock);
			#1;
		end
	endtask
endmodule // bdi_cpu_model

/* dv/bdi_top_test.sv */
// Self-checking bench for the board decode block
`timescale 1ns/100ps
`include "bdi_map.svh"
module bdi_top_test;
	import bdi_pkg::*;
	logic       clock = 1'b0;
	logic       sys_rst = 1'b1;
	logic       ce = 1'b1;
	logic       port1_stb_n = 1'b1;
	logic       port2_stb_n = 1'b1;
	logic       user_irq_n = 1'b1;
	logic [7:0] port1_in = 8'h00;
	logic [7:0] port2_in = 8'h00;
	logic [5:0] port34_in = 6'h2a;
	bdi_req_s   req;
	bdi_irq_s   irq;
	logic [7:0] rdata, irq_vector, port1_out, port2_out, q;
	logic [5:0] port34_out;
	logic       rvalid, rom_sel, ram_sel, port1_oe, port2_oe, irq_any, timer_tc, instr_tick;
	int         rom_hits = 0;
	int         ram_hits = 0;
	int         rom_base;
	int         ram_base;
	int         mismatches = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	int         n;
	logic [15:0] addrs [7] = '{16'h0000, 16'h0fff, 16'h1000, 16'h3eff, 16'h3f00, 16'h3fff, 16'h4000};
	logic [6:0]  rom_exp = 7'b1100000;
	logic [6:0]  ram_exp = 7'b0000110;

	always #10 clock = ~clock;

	bdi_top i_bdi_top (.clock(clock), .sys_rst(sys_rst), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
		.rom_sel(rom_sel), .ram_sel(ram_sel), .port1_in(port1_in), .port1_out(port1_out), .port1_oe(port1_oe),
		.port2_in(port2_in), .port2_out(port2_out), .port2_oe(port2_oe), .port34_in(port34_in),
		.port34_out(port34_out), .port1_stb_n(port1_stb_n), .port2_stb_n(port2_stb_n), .user_irq_n(user_irq_n),
		.irq(irq), .irq_vector(irq_vector), .irq_any(irq_any), .timer_tc(timer_tc), .instr_tick(instr_tick));
	bdi_cpu_model i_bdi_cpu_model (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));

	// ---------------------------------------------
	// Tasks
	// ---------------------------------------------
	always @(posedge clock) begin
		rom_hits <= rom_hits + int'(rom_sel);
		ram_hits <= ram_hits + int'(ram_sel);
		cycles++;
		if (cycles == 15000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic final_report();
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d);
		i_bdi_cpu_model.cycle(1'b1, wr, {8'h00, a}, d, q);
	endtask
	// Select flags are registered, so two spare cycles let them land
	task automatic mem(input logic wr, input logic [15:0] a, input logic [7:0] d);
		rom_base = rom_hits;
		ram_base = ram_hits;
		i_bdi_cpu_model.cycle(1'b0, wr, a, d, q);
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic wait_pulse(input logic tick, output int cnt);
		cnt = 0;
		do begin
			@(posedge clock);
			#1 cnt++;
		end while (cnt < 3000 && (tick ? instr_tick : timer_tc) !== 1'b1);
	endtask
	task automatic strobe(input logic two);
		if (two) port2_stb_n = 1'b0; else port1_stb_n = 1'b0;
		repeat (2) @(posedge clock);
		#1 port1_stb_n = 1'b1;
		port2_stb_n = 1'b1;
		repeat (3) @(posedge clock);
		#1;
	endtask

	// ---------------------------------------------
	// Sequence
	// ---------------------------------------------
	initial begin
		repeat (8) @(posedge clock);
		#1 sys_rst = 1'b0;
		chk_byte(irq_vector, 8'h00);
		chk_bit(rvalid | timer_tc | irq_any, 1'b0);
		for (int i = 0; i < 7; i++) begin
			mem(1'b0, addrs[i], 8'h00);
			chk_byte(8'(rom_hits - rom_base), {7'h00, rom_exp[6 - i]});
			chk_byte(8'(ram_hits - ram_base), {7'h00, ram_exp[6 - i]});
		end
		mem(1'b1, 16'h3f00, 8'ha5);
		mem(1'b1, 16'h3fff, 8'h5a);
		mem(1'b0, 16'h3f00, 8'h00);
		chk_byte(q, 8'ha5);
		mem(1'b0, 16'h3fff, 8'h00);
		chk_byte(q, 8'h5a);
		io(1'b1, `BDI_IO_CMD, 8'h03);
		io(1'b1, `BDI_IO_PORT1, 8'h3c);
		io(1'b1, `BDI_IO_PORT2, 8'hc3);
		io(1'b1, `BDI_IO_PORT34, 8'h15);
		chk_byte(port1_out, 8'h3c);
		chk_byte(port2_out, 8'hc3);
		chk_byte({2'b00, port34_out}, 8'h15);
		chk_bit(port1_oe & port2_oe, 1'b1);
		io(1'b0, `BDI_IO_PORT1, 8'h00);
		chk_byte(q, 8'h3c);
		io(1'b0, 8'h06, 8'h00);
		chk_byte(q, 8'h00);
		io(1'b0, `BDI_IO_PORT34, 8'h00);
		chk_byte(q, 8'h2a);
		// Plain mode: strobe must stay silent
		io(1'b1, `BDI_IO_CMD, 8'h00);
		port1_in = 8'h9a;
		strobe(1'b0);
		chk_bit(irq.r55, 1'b0);
		io(1'b1, `BDI_IO_CMD, 8'h14);
		strobe(1'b0);
		chk_bit(irq.r55, 1'b1);
		chk_byte(irq_vector, `BDI_VEC_R55);
		io(1'b1, `BDI_IO_CMD, 8'h3c);
		port2_in = 8'h6b;
		strobe(1'b1);
		chk_bit(irq.r65, 1'b1);
		chk_byte(irq_vector, `BDI_VEC_R65);
		port1_in = 8'h00;
		port2_in = 8'h00;
		io(1'b0, `BDI_IO_PORT1, 8'h00);
		chk_byte(q, 8'h9a);
		io(1'b0, `BDI_IO_PORT2, 8'h00);
		chk_byte(q, 8'h6b);
		repeat (3) @(posedge clock);
		#1 chk_bit(irq_any, 1'b0);
		// Timer, length 2, continuous reload
		io(1'b1, `BDI_IO_TLOW, 8'h02);
		io(1'b1, `BDI_IO_THIGH, 8'h40);
		io(1'b1, `BDI_IO_CMD, 8'hc0);
		wait_pulse(1'b0, n);
		chk_bit(timer_tc, 1'b1);
		repeat (3) @(posedge clock);
		#1 chk_bit(irq.r75, 1'b1);
		chk_byte(irq_vector, `BDI_VEC_R75);
		// Mark to mark, less the three cycles spent before counting
		wait_pulse(1'b0, n);
		chk_byte(n[7:0], 8'(2 * `BDI_TREF_CYC - 3));
		chk_byte(8'(n >> 8), 8'((2 * `BDI_TREF_CYC - 3) >> 8));
		io(1'b0, `BDI_IO_TLOW, 8'h00);
		chk_byte(q, 8'h02);
		io(1'b0, `BDI_IO_THIGH, 8'h00);
		chk_byte(q, 8'h40);
		// Stop after the next completion
		io(1'b1, `BDI_IO_CMD, 8'h80);
		wait_pulse(1'b0, n);
		chk_bit(timer_tc, 1'b1);
		io(1'b0, `BDI_IO_CMD, 8'h00);
		chk_byte(q, 8'h40);
		io(1'b0, `BDI_IO_CMD, 8'h00);
		chk_byte(q, 8'h00);
		wait_pulse(1'b0, n);
		chk_bit(timer_tc, 1'b0);
		// Start then stop at once: no completion may follow
		io(1'b1, `BDI_IO_CMD, 8'hc0);
		io(1'b1, `BDI_IO_CMD, 8'h40);
		wait_pulse(1'b0, n);
		chk_bit(timer_tc, 1'b0);
		// Trap is active low from outside and outranks all others; held off while the enable is low
		ce = 1'b0;
		user_irq_n = 1'b0;
		repeat (3) @(posedge clock);
		#1 chk_bit(irq.trap, 1'b0);
		ce = 1'b1;
		repeat (3) @(posedge clock);
		#1 chk_bit(irq.trap & irq_any, 1'b1);
		chk_byte(irq_vector, `BDI_VEC_TRAP);
		user_irq_n = 1'b1;
		repeat (3) @(posedge clock);
		#1 chk_bit(irq.trap, 1'b0);
		wait_pulse(1'b1, n);
		wait_pulse(1'b1, n);
		chk_byte(n[7:0], 8'd101);
		final_report();
	end
endmodule // bdi_top_test
